// file: verilog/vcmd_port.sv
// Contract
// - argument writes dropped while busy
// - code writes dropped while busy
// - accepted code write clears reply, sets busy
// - codes: 0 null, 1 alloc, 2 free
// - reply result 63:8, bits 7:3 zero
// - status 0 success, 1 undefined command
// - busy bit 1 until completion
// - alloc returns id or status 2
// - free bad id gives status 2, result zero
// - null completes success, zero result
// - unsupported: both registers read zero, ignore writes
//
// top of the virtual command port: apb registers, command sequencer
// assumes apb master on pclk; 64-bit registers reached as two 32-bit words
//
// The APB register port was decided locally.
`timescale 1ns/1ns
module vcmd_port
    import vcmd_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // status
    output logic             busy
);

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic [63:0] request;
        logic [63:0] reply;
        logic        support;
        phase_t      phase;
        logic [31:0] rdata;
        logic        ready;
        logic        busy;
    } port_state_t;

    port_state_t st_reg;
    port_state_t st_next;

    apb_req_t    bus;
    logic        wr_stb;
    logic        rd_stb;
    pool_req_t   preq;
    pool_rsp_t   prsp;

    always_comb begin
        bus.sel    = psel;
        bus.enable = penable;
        bus.write  = pwrite;
        bus.addr   = paddr;
        bus.wdata  = pwdata;
    end

    vcmd_apb_slave u_slave (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (bus),
        .wr_stb  (wr_stb),
        .rd_stb  (rd_stb)
    );

    vcmd_id_pool u_pool (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (preq),
        .rsp     (prsp)
    );

    // =========================================================
    // pool request: issued in the cycle the sequencer executes
    // =========================================================
    always_comb begin
        preq       = '0;
        preq.id    = st_reg.request[PASID_LSB +: PASID_W];
        if (st_reg.phase == PH_EXEC) begin
            preq.alloc = st_reg.request[CODE_LSB +: CODE_W] == CMD_ALLOC;
            preq.free  = st_reg.request[CODE_LSB +: CODE_W] == CMD_FREE;
        end
    end

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        logic [7:0] code;
        code          = st_reg.request[CODE_LSB +: CODE_W];
        st_next       = st_reg;
        st_next.ready = 1'b0;
        st_next.busy  = st_reg.reply[BUSY_BIT];

        // register writes
        if (wr_stb && !st_reg.ready) begin
            st_next.ready = 1'b1;
            if (bus.addr == CTRL_ADDR) begin
                st_next.support = bus.wdata[CTRL_SUPPORT_BIT];
            end else if (st_reg.support && !st_reg.reply[BUSY_BIT]) begin
                if (bus.addr == REQ_HI_ADDR) begin
                    st_next.request[63:32] = bus.wdata;
                end else if (bus.addr == REQ_LO_ADDR) begin
                    // low word holds the code: writing it starts a command
                    st_next.request[31:0] = bus.wdata;
                    st_next.reply = REPLY_RESET;
                    st_next.reply[BUSY_BIT] = 1'b1;
                    st_next.phase = PH_EXEC;
                end
            end
        end

        // register reads
        if (rd_stb && !st_reg.ready) begin
            st_next.ready = 1'b1;
            st_next.rdata = UNMAPPED_READ;
            if (bus.addr == CTRL_ADDR) begin
                st_next.rdata = {31'h0, st_reg.support};
            end else if (st_reg.support) begin
                case (bus.addr)
                    REQ_LO_ADDR:   st_next.rdata = st_reg.request[31:0];
                    REQ_HI_ADDR:   st_next.rdata = st_reg.request[63:32];
                    REPLY_LO_ADDR: st_next.rdata = st_reg.reply[31:0];
                    REPLY_HI_ADDR: st_next.rdata = st_reg.reply[63:32];
                    default:       st_next.rdata = UNMAPPED_READ;
                endcase
            end
        end

        // command sequencer
        case (st_reg.phase)
            PH_IDLE: begin
                // result was posted last cycle with busy held: drop busy
                // now; no request write can be accepted while busy is still set
                if (st_reg.reply[BUSY_BIT]) begin
                    st_next.reply[BUSY_BIT] = 1'b0;
                end
            end
            PH_EXEC: begin
                case (code)
                    CMD_NULL: begin
                        // zero result, success
                        st_next.reply = REPLY_RESET;
                        st_next.phase = PH_IDLE;
                    end
                    CMD_ALLOC, CMD_FREE: begin
                        st_next.phase = PH_WAIT;
                    end
                    default: begin
                        st_next.reply = REPLY_RESET;
                        st_next.reply[STAT_LSB +: 2] = ST_UNDEFINED;
                        st_next.phase = PH_IDLE;
                    end
                endcase
            end
            PH_WAIT: begin
                if (prsp.done) begin
                    st_next.reply = REPLY_RESET;
                    // busy stays one more cycle so a chained write is dropped
                    st_next.reply[BUSY_BIT] = 1'b1;
                    if (!prsp.ok) begin
                        st_next.reply[STAT_LSB +: 2] = ST_CMD_ERR;
                    end else if (code == CMD_ALLOC) begin
                        st_next.reply[PASID_LSB +: PASID_W] = prsp.id;
                    end
                    st_next.phase = PH_IDLE;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg         <= '0;
            st_reg.request <= REQ_RESET;
            st_reg.reply   <= REPLY_RESET;
            st_reg.support <= SUPPORT_RESET;
            st_reg.phase   <= PH_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    always_comb begin
        prdata  = st_reg.rdata;
        pready  = st_reg.ready;
        pslverr = 1'b0;
        busy    = st_reg.busy;
    end

endmodule : vcmd_port

// file: verilog/vcmd_pkg.sv
// package: register map, field layout, command codes, status codes and bus types
// assumes a 32-bit APB slave in front of 64-bit registers split into words
package vcmd_pkg;

    // =========================================================
    // register map (byte addresses, word aligned)
    // =========================================================
    localparam logic [11:0] REQ_LO_ADDR   = 12'he10;
    localparam logic [11:0] REQ_HI_ADDR   = 12'he14;
    localparam logic [11:0] REPLY_LO_ADDR = 12'he20;
    localparam logic [11:0] REPLY_HI_ADDR = 12'he24;
    localparam logic [11:0] CTRL_ADDR     = 12'he30;

    // =========================================================
    // field layout
    // =========================================================
    localparam int CODE_LSB   = 0;
    localparam int CODE_W     = 8;
    localparam int ARG_LSB    = 8;
    localparam int ARG_W      = 56;
    localparam int PASID_LSB  = 8;
    localparam int PASID_W    = 20;
    localparam int BUSY_BIT   = 0;
    localparam int STAT_LSB   = 1;
    localparam int CTRL_SUPPORT_BIT = 0;

    // =========================================================
    // reset values
    // =========================================================
    localparam logic [63:0] REQ_RESET   = 64'h0;
    localparam logic [63:0] REPLY_RESET = 64'h0;
    localparam logic        SUPPORT_RESET = 1'b1;
    localparam logic [31:0] UNMAPPED_READ = 32'h0;

    // =========================================================
    // command and status codes
    // =========================================================
    typedef enum logic [7:0] {
        CMD_NULL  = 8'h00,
        CMD_ALLOC = 8'h01,
        CMD_FREE  = 8'h02
    } cmd_code_t;

    typedef enum logic [1:0] {
        ST_OK        = 2'h0,
        ST_UNDEFINED = 2'h1,
        ST_CMD_ERR   = 2'h2
    } status_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_EXEC  = 2'b01,
        PH_WAIT  = 2'b10
    } phase_t;

    // pool request into the allocator and its answer
    typedef struct packed {
        logic               alloc;
        logic               free;
        logic [PASID_W-1:0] id;
    } pool_req_t;

    typedef struct packed {
        logic               done;
        logic               ok;
        logic [PASID_W-1:0] id;
    } pool_rsp_t;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_t;

endpackage : vcmd_pkg

// file: verilog/vcmd_apb_slave.sv
// apb slave front end: turns an apb access into read/write strobes held for the whole access phase
// assumes pclk domain master; vcmd_port answers every access after one wait state
`timescale 1ns/1ns
module vcmd_apb_slave
    import vcmd_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb request
    input  wire apb_req_t    bus,
    // decoded strobes
    output logic             wr_stb,
    output logic             rd_stb
);

    // =========================================================
    // strobes
    // =========================================================
    always_comb begin
        wr_stb = bus.sel & bus.enable & bus.write;
        rd_stb = bus.sel & bus.enable & ~bus.write;
    end

endmodule : vcmd_apb_slave

// file: verilog/vcmd_id_pool.sv
// identifier pool: one bit per identifier, allocate lowest free, free by id
// assumes one request at a time; answers one cycle after the request
`timescale 1ns/1ns
module vcmd_id_pool
    import vcmd_pkg::*;
#(
    parameter int POOL_SIZE = 16
) (
    // clock and reset
    input  wire logic      pclk,
    input  wire logic      presetn,
    // request and answer
    input  wire pool_req_t req,
    output pool_rsp_t      rsp
);

    typedef struct packed {
        logic [POOL_SIZE-1:0] used;
        pool_rsp_t            rsp;
    } pool_state_t;

    pool_state_t st_reg;
    pool_state_t st_next;

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        st_next          = st_reg;
        st_next.rsp.done = 1'b0;
        if (req.alloc) begin
            st_next.rsp.done = 1'b1;
            st_next.rsp.ok   = 1'b0;
            st_next.rsp.id   = '0;
            for (int i = POOL_SIZE - 1; i >= 0; i--) begin
                if (!st_reg.used[i]) begin
                    st_next.rsp.ok = 1'b1;
                    st_next.rsp.id = PASID_W'(i);
                end
            end
            if (st_next.rsp.ok) begin
                st_next.used[st_next.rsp.id[$clog2(POOL_SIZE)-1:0]] = 1'b1;
            end
        end else if (req.free) begin
            st_next.rsp.done = 1'b1;
            st_next.rsp.id   = '0;
            st_next.rsp.ok   = (req.id < PASID_W'(POOL_SIZE))
                && st_reg.used[req.id[$clog2(POOL_SIZE)-1:0]];
            if (st_next.rsp.ok) begin
                st_next.used[req.id[$clog2(POOL_SIZE)-1:0]] = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        rsp = st_reg.rsp;
    end

endmodule : vcmd_id_pool

// file: dv/vcmd_port_checker.sv
// checker: bus and command-port assertions on the vcmd_port pins
// assumes one pclk domain; bound to vcmd_port below
`timescale 1ns/1ns
module vcmd_port_checker
    import vcmd_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // status
    input wire logic        busy
);
    // =====================================
    // helpers
    // =====================================
    logic       sup;
    logic [1:0] st_d;
    logic       acc;
    logic       start;
    logic       rd;
    logic       known;
    assign acc   = psel && penable && !pready;
    assign start = acc && pwrite && paddr == REQ_LO_ADDR && !busy && sup;
    assign rd    = pready && !pwrite;
    assign known = paddr inside {REQ_LO_ADDR, REQ_HI_ADDR, REPLY_LO_ADDR,
                                 REPLY_HI_ADDR, CTRL_ADDR};
    // support bit follows writes to the control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup  <= SUPPORT_RESET;
            st_d <= 2'h0;
        end else begin
            if (acc && pwrite && paddr == CTRL_ADDR) begin
                sup <= pwdata[CTRL_SUPPORT_BIT];
            end
            st_d <= {st_d[0], start};
        end
    end
    // =====================================
    // properties
    // =====================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_start;
        start;
    endsequence
    sequence s_rdreply;
        rd && paddr == REPLY_LO_ADDR;
    endsequence
    property p_wait;
        acc |=> pready;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_qual;
        pready |-> psel && penable;
    endproperty
    property p_noerr;
        !pslverr;
    endproperty
    property p_start;
        s_start |-> ##2 busy;
    endproperty
    property p_cause;
        $rose(busy) |-> st_d[1];
    endproperty
    property p_bound;
        $rose(busy) |-> ##[1:3] !busy;
    endproperty
    property p_rsvd;
        s_rdreply |-> prdata[7:3] == 5'h0;
    endproperty
    property p_stat;
        s_rdreply |-> prdata[2:1] != 2'h3;
    endproperty
    property p_unmap;
        rd && !known |-> prdata == 32'h0;
    endproperty
    property p_unsup;
        rd && !sup && paddr inside {[REQ_LO_ADDR:REPLY_HI_ADDR]}
            |-> prdata == 32'h0;
    endproperty
    a_wait: assert property (p_wait) else $error("no pready after wait");
    a_pulse: assert property (p_pulse) else $error("pready too long");
    a_qual: assert property (p_qual) else $error("pready outside access");
    a_noerr: assert property (p_noerr) else $error("pslverr raised");
    a_start: assert property (p_start) else $error("no busy");
    a_cause: assert property (p_cause) else $error("stray busy");
    a_bound: assert property (p_bound) else $error("busy hangs");
    a_rsvd: assert property (p_rsvd) else $error("reply 7:3 set");
    a_stat: assert property (p_stat) else $error("status 3");
    a_unmap: assert property (p_unmap) else $error("unmapped read data");
    a_unsup: assert property (p_unsup) else $error("unsup read");
endmodule : vcmd_port_checker

bind vcmd_port vcmd_port_checker i_vcmd_port_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));

// file: dv/vcmd_port_tb.sv
// testbench: drives vcmd_port over apb, checks registers and commands
// assumes the vcmd_pkg map, a 16-entry pool and the bound checker
`timescale 1ns/1ns
module vcmd_port_tb
    import vcmd_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic [31:0] r;
    int          error_cnt;
    int          checks;
    int          cyc;

    vcmd_port i_vcmd_port (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy));

    // =====================================
    // bus tasks
    // =====================================
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic print_verdict;
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // bb chains on the previous transfer, keep leaves psel up for it
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, input logic bb,
                        input logic keep);
        if (!bb) begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
        end
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        penable <= 1'b0;
        if (!keep) begin
            psel <= 1'b0;
        end
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input string n,
                      input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 1'b0, 1'b0);
        chk(n, e, r);
    endtask : rd

    task automatic poll;
        do begin
            xfer(1'b0, REPLY_LO_ADDR, 32'h0, 1'b0, 1'b0);
        end while (r[BUSY_BIT] !== 1'b0);
    endtask : poll

    task automatic cmd(input logic [31:0] hi, input logic [31:0] lo,
                       input logic [31:0] elo);
        wr(REQ_HI_ADDR, hi);
        wr(REQ_LO_ADDR, lo);
        poll();
        rd(REPLY_LO_ADDR, "reply_lo", elo);
        rd(REPLY_HI_ADDR, "reply_hi", 32'h0);
    endtask : cmd

    // =====================================
    // scenarios
    // =====================================
    task automatic t_basic;
        chk("busy", 32'h0, {31'h0, busy});
        rd(REPLY_LO_ADDR, "reply_lo", REPLY_RESET[31:0]);
        rd(CTRL_ADDR, "ctrl", {31'h0, SUPPORT_RESET});
        cmd(32'h1234_5678, 32'habcd_ef00, 32'h0);
        rd(REQ_HI_ADDR, "req_hi", 32'h1234_5678);
        cmd(32'h0, 32'h3, 32'h2);
        cmd(32'h0, 32'hff, 32'h2);
    endtask : t_basic

    task automatic t_pool;
        for (int i = 0; i < 16; i++) begin
            cmd(32'h0, 32'h1, i << 8);
        end
        cmd(32'h0, 32'h1, 32'h4);
        cmd(32'h0, 32'h502, 32'h0);
        cmd(32'h0, 32'h502, 32'h4);
        cmd(32'h0, 32'h1002, 32'h4);
        cmd(32'h0, 32'h1, 32'h500);
        cmd(32'hffff_ffff, 32'hf000_0702, 32'h0);
    endtask : t_pool

    task automatic t_drop;
        xfer(1'b1, REQ_LO_ADDR, 32'h1, 1'b0, 1'b1);
        xfer(1'b1, REQ_LO_ADDR, 32'hffff_ff03, 1'b1, 1'b0);
        poll();
        rd(REPLY_LO_ADDR, "reply_lo", 32'h700);
        rd(REQ_LO_ADDR, "req_lo", 32'h1);
        xfer(1'b1, REQ_LO_ADDR, 32'h1, 1'b0, 1'b1);
        xfer(1'b1, REQ_HI_ADDR, 32'h0, 1'b1, 1'b0);
        poll();
        rd(REQ_HI_ADDR, "req_hi", 32'hffff_ffff);
    endtask : t_drop

    task automatic t_unsup;
        wr(CTRL_ADDR, 32'h0);
        rd(REQ_LO_ADDR, "req_lo", 32'h0);
        rd(REPLY_LO_ADDR, "reply_lo", 32'h0);
        wr(REQ_LO_ADDR, 32'h0);
        wr(CTRL_ADDR, 32'h1);
        rd(REQ_LO_ADDR, "req_lo", 32'h1);
        rd(REPLY_LO_ADDR, "reply_lo", 32'h4);
        wr(12'he40, 32'hffff_ffff);
        rd(12'he40, "unmapped", UNMAPPED_READ);
    endtask : t_unsup

    // =====================================
    // clock, timeout, sequence
    // =====================================
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h0;
        pwdata  = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_basic();
        t_pool();
        t_drop();
        t_unsup();
        print_verdict();
    end
endmodule : vcmd_port_tb
